// ===== hw/dsw_sync.sv
// two flip-flop synchroniser with edge outputs
`timescale 1ns/1ps
`default_nettype none
module dsw_sync
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // async level in
  input wire logic async_i,
  // synced level and edges
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  always_comb
  begin
    next_meta = async_i;
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta <= 1'b1;
      sync <= 1'b1;
      prev <= 1'b1;
    end
    else
    begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign level_o = sync;
  assign rise_o = sync & ~prev;
  assign fall_o = ~sync & prev;
endmodule : dsw_sync
`default_nettype wire

// ===== hw/dsw_wiper_if.sv
// SPI / I2C serial wiper control interface
// Overview of operation
// - SPI words are 8 bits, most significant bit first
// - SPI shifts serial in on each clock rise while select low
// - chip select rising copies shift register into wiper
// - extra SPI bits push out older ones; last eight kept
// - chain out is pull-down only; board supplies pull-up
// - I2C address is 010110 plus address select pin level
// - START (data falls, clock high) makes next byte the address
// - matching address acked on ninth clock, else idle till START
// - read/write high reads device, low writes it
// - write: instruction byte follows; bit 7 and bits 4..0 ignored
// - instruction bit 6 writes midscale into wiper
// - instruction bit 5 forces shutdown, wiper kept and writable
// - data byte acked on ninth clock and loaded into wiper
// - data line changes only while clock low
// - read: wiper driven msb first after address ack
// - STOP (data rises, clock high) returns to idle
// - further write bytes are new wiper values, same instruction
// - repeated reads return current wiper; code returns one byte per read, then releases data line till next START
// - midscale code is 80 hex
// - wiper presets to midscale at power-on
`timescale 1ns/1ps
`default_nettype none
module dsw_wiper_if
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // straps
  input wire logic interface_select_pin_i,
  input wire logic address_select_pin_i,
  // serial pins
  input wire logic serial_clk_i,
  input wire logic serial_in_pin_i,
  input wire logic chip_select_n_i,
  // i2c data drive
  output logic sda_o,
  output logic sda_oe_o,
  // chain serial out, open drain
  output logic chain_serial_out_o,
  output logic chain_serial_out_oe_o,
  // wiper state
  output logic [7:0] wiper_register_o,
  output logic shutdown_o
);
  typedef enum logic [2:0] {DSW_IDLE, DSW_ADDR, DSW_ACK, DSW_INSTR, DSW_DATA,
    DSW_READ, DSW_WAIT} dsw_state_t;

  logic scl;
  logic scl_rise;
  logic scl_fall;
  logic serial_in_pin;
  logic sdi_rise;
  logic sdi_fall;
  logic cs_n;
  logic cs_rise;
  logic mode_sel;
  logic addr_sel;
  logic strap_meta;
  logic next_strap_meta;
  logic [1:0] strap_sync;
  logic [1:0] next_strap_sync;

  // ==========================================
  // pin synchronisers
  dsw_sync u_scl
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(serial_clk_i),
    .level_o(scl),
    .rise_o(scl_rise),
    .fall_o(scl_fall)
  );
  dsw_sync u_sdi
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(serial_in_pin_i),
    .level_o(serial_in_pin),
    .rise_o(sdi_rise),
    .fall_o(sdi_fall)
  );
  dsw_sync u_cs
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(chip_select_n_i),
    .level_o(cs_n),
    .rise_o(cs_rise),
    .fall_o()
  );

  always_comb
  begin
    next_strap_meta = interface_select_pin_i;
    next_strap_sync = {strap_meta, address_select_pin_i};
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      strap_meta <= 1'b0;
      strap_sync <= 2'h0;
    end
    else
    begin
      strap_meta <= next_strap_meta;
      strap_sync <= next_strap_sync;
    end
  end

  // address select second stage
  logic addr_meta;
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      addr_meta <= 1'b0;
    else
      addr_meta <= strap_sync[0];
  end
  assign mode_sel = strap_sync[1];
  assign addr_sel = addr_meta;

  // ==========================================
  // serial engine state
  dsw_state_t state;
  dsw_state_t next_state;
  dsw_state_t after_ack;
  dsw_state_t next_after_ack;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] wiper;
  logic [7:0] next_wiper;
  logic shutdown;
  logic next_shutdown;
  logic sda_drive_low;
  logic next_sda_drive_low;
  logic chain_low;
  logic next_chain_low;
  logic start_det;
  logic stop_det;

  assign start_det = scl & sdi_fall;
  assign stop_det = scl & sdi_rise;

  always_comb
  begin
    next_state = state;
    next_after_ack = after_ack;
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_wiper = wiper;
    next_shutdown = shutdown;
    next_sda_drive_low = sda_drive_low;
    next_chain_low = chain_low;
    if (!mode_sel)
    begin
      next_state = DSW_IDLE;
      next_sda_drive_low = 1'b0;
      if (!cs_n && scl_rise)
        next_shift = {shift[6:0], serial_in_pin};
      if (!cs_n && scl_fall)
        next_chain_low = ~shift[7];
      if (cs_rise)
      begin
        next_wiper = shift;
        next_chain_low = 1'b0;
      end
    end
    else if (start_det)
    begin
      next_state = DSW_ADDR;
      next_bit_cnt = dsw_pkg::BIT_CNT_RESET;
      next_sda_drive_low = 1'b0;
    end
    else if (stop_det)
    begin
      next_state = DSW_IDLE;
      next_sda_drive_low = 1'b0;
    end
    else
    begin
      unique case (state)
        DSW_IDLE, DSW_WAIT:
        begin
          next_sda_drive_low = 1'b0;
        end
        DSW_ADDR, DSW_INSTR, DSW_DATA:
        begin
          if (scl_rise)
          begin
            next_shift = {shift[6:0], serial_in_pin};
            next_bit_cnt = 4'(bit_cnt + 4'h1);
          end
          if (scl_fall && bit_cnt == dsw_pkg::BITS_PER_BYTE)
          begin
            next_bit_cnt = dsw_pkg::BIT_CNT_RESET;
            next_state = DSW_ACK;
            next_sda_drive_low = 1'b1;
            if (state == DSW_ADDR)
            begin
              if (shift[7:1] != {dsw_pkg::ADDR_UPPER, addr_sel})
              begin
                next_state = DSW_WAIT;
                next_sda_drive_low = 1'b0;
              end
              else if (shift[0] == dsw_pkg::RW_READ)
                next_after_ack = DSW_READ;
              else
                next_after_ack = DSW_INSTR;
            end
            else if (state == DSW_INSTR)
            begin
              next_shutdown = shift[dsw_pkg::SD_BIT_POS];
              if (shift[dsw_pkg::RS_BIT_POS])
                next_wiper = dsw_pkg::MIDSCALE_CODE;
              next_after_ack = DSW_DATA;
            end
            else
            begin
              next_wiper = shift;
              next_after_ack = DSW_DATA;
            end
          end
        end
        DSW_ACK:
        begin
          if (scl_fall)
          begin
            next_state = after_ack;
            next_sda_drive_low = 1'b0;
            if (after_ack == DSW_READ)
            begin
              next_shift = wiper;
              next_sda_drive_low = ~wiper[7];
              next_bit_cnt = 4'h1;
            end
          end
        end
        DSW_READ:
        begin
          if (scl_fall)
          begin
            if (bit_cnt == dsw_pkg::BITS_PER_BYTE)
            begin
              next_sda_drive_low = 1'b0;
              next_state = DSW_WAIT;
            end
            else
            begin
              next_shift = {shift[6:0], 1'b0};
              next_sda_drive_low = ~shift[6];
              next_bit_cnt = 4'(bit_cnt + 4'h1);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= DSW_IDLE;
      after_ack <= DSW_IDLE;
      shift <= 8'h00;
      bit_cnt <= dsw_pkg::BIT_CNT_RESET;
      wiper <= dsw_pkg::MIDSCALE_CODE;
      shutdown <= 1'b0;
      sda_drive_low <= 1'b0;
      chain_low <= 1'b0;
    end
    else
    begin
      state <= next_state;
      after_ack <= next_after_ack;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      wiper <= next_wiper;
      shutdown <= next_shutdown;
      sda_drive_low <= next_sda_drive_low;
      chain_low <= next_chain_low;
    end
  end

  // ==========================================
  // outputs
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_drive_low;
  assign chain_serial_out_o = 1'b0;
  assign chain_serial_out_oe_o = chain_low;
  assign wiper_register_o = wiper;
  assign shutdown_o = shutdown;
endmodule : dsw_wiper_if
`default_nettype wire

// ===== shared/dsw_pkg.sv
// constants for the dual serial wiper interface
package dsw_pkg;
  localparam int WIPER_W = 8;
  localparam logic [7:0] MIDSCALE_CODE = 8'h80;
  localparam logic [5:0] ADDR_UPPER = 6'h16;
  localparam int RS_BIT_POS = 6;
  localparam int SD_BIT_POS = 5;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int SYNC_STAGES = 2;
  localparam logic RW_READ = 1'b1;
endpackage : dsw_pkg

// ===== verification/dsw_host_model.sv
// host master model for the spi and i2c pins
`timescale 1ns/1ps
`default_nettype none
module dsw_host_model
(
  // clock and device drives
  input wire logic ref_clk_i,
  input wire logic sda_oe_i,
  input wire logic chain_oe_i,
  // host pins
  output logic scl_o,
  output logic cs_n_o,
  output logic dat_o
);
  logic [31:0] so;
  initial
  begin
    scl_o = 1'b0;
    cs_n_o = 1'b1;
    dat_o = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : w
  // spi frame msb first, chain node sampled with pull-up
  task automatic spi(input logic [31:0] d, input int n);
    so = '0;
    cs_n_o = 1'b0;
    w(4);
    for (int i = n - 1; i >= 0; i--)
    begin
      dat_o = d[i];
      w(4);
      scl_o = 1'b1;
      w(3);
      so = {so[30:0], !chain_oe_i};
      w(1);
      scl_o = 1'b0;
    end
    w(4);
    cs_n_o = 1'b1;
    dat_o = !dat_o;
    w(8);
  endtask : spi
  // data moves only with scl low
  task automatic bit_io(input logic v, output logic s);
    scl_o = 1'b0;
    w(2);
    dat_o = v;
    w(2);
    scl_o = 1'b1;
    w(2);
    s = dat_o & !sda_oe_i;
    w(2);
  endtask : bit_io
  // start and stop
  task automatic start();
    dat_o = 1'b1;
    scl_o = 1'b1;
    w(4);
    dat_o = 1'b0;
    w(4);
  endtask : start
  task automatic stop();
    bit_io(1'b0, so[0]);
    dat_o = 1'b1;
    w(4);
  endtask : stop
  // byte msb first, ninth pulse released for ack or nack
  task automatic xfer(input logic [7:0] b, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], q[i]);
    bit_io(1'b1, ack);
  endtask : xfer
endmodule : dsw_host_model
`default_nettype wire

// ===== verification/dsw_wiper_if_checker.sv
// port assertions for the wiper interface
`timescale 1ns/1ps
`default_nettype none
module dsw_wiper_if_checker
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // inputs
  input wire logic interface_select_pin_i,
  input wire logic address_select_pin_i,
  input wire logic serial_clk_i,
  input wire logic serial_in_pin_i,
  input wire logic chip_select_n_i,
  // outputs
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic chain_serial_out_o,
  input wire logic chain_serial_out_oe_o,
  input wire logic [7:0] wiper_register_o,
  input wire logic shutdown_o
);
  // ====
  // phases
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence spi_s;
    !interface_select_pin_i;
  endsequence
  sequence i2c_hi_s;
    interface_select_pin_i && serial_clk_i;
  endsequence
  mid_preset_a: assert property (!$past(rst_n_i) |-> wiper_register_o == 8'h80)
    else $error("no preset");
  open_drain_a: assert property (!sda_o && !chain_serial_out_o)
    else $error("driven high");
  spi_quiet_a: assert property (spi_s [*8] |-> !sda_oe_o)
    else $error("sda in spi");
  spi_load_a: assert property ((!interface_select_pin_i && chip_select_n_i) [*8] |=>
    $stable(wiper_register_o)) else $error("wiper moved");
  spi_shut_a: assert property (spi_s [*8] |=> $stable(shutdown_o))
    else $error("shutdown moved");
  spi_chain_a: assert property ((!interface_select_pin_i && serial_clk_i) [*3] |=>
    $stable(chain_serial_out_oe_o)) else $error("chain moved");
  i2c_hold_a: assert property (i2c_hi_s [*3] |=>
    $stable({wiper_register_o, shutdown_o})) else $error("load in high");
  sda_hold_a: assert property (i2c_hi_s [*3] |=> $stable(sda_oe_o))
    else $error("sda moved");
endmodule : dsw_wiper_if_checker
bind dsw_wiper_if dsw_wiper_if_checker chk_u (.*);
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the wiper interface
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk;
  logic rst_n;
  logic sel;
  logic ad;
  logic scl;
  logic cs_n;
  logic dat;
  logic sda_oe;
  logic ch_oe;
  logic [7:0] wiper;
  logic shut;
  logic [7:0] ew;
  logic es;
  int fails;
  int n_checks;
  int cyc;
  int nb[3] = '{8, 12, 16};
  logic [8:0] op[6] = '{9'h100, 9'h000, 9'h120, 9'h140, 9'h160, 9'h100};
  int nd[6] = '{2, 1, 1, 0, 1, 0};
  wire serial_in_pin = dat & !sda_oe;
  // ====
  // clock, design, host
  initial
  begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  dsw_wiper_if dut_u (.ref_clk_i(clk), .rst_n_i(rst_n), .interface_select_pin_i(sel),
    .address_select_pin_i(ad), .serial_clk_i(scl), .serial_in_pin_i(serial_in_pin),
    .chip_select_n_i(cs_n), .sda_o(), .sda_oe_o(sda_oe), .chain_serial_out_o(),
    .chain_serial_out_oe_o(ch_oe), .wiper_register_o(wiper), .shutdown_o(shut));
  dsw_host_model host_u (.ref_clk_i(clk), .sda_oe_i(sda_oe), .chain_oe_i(ch_oe),
    .scl_o(scl), .cs_n_o(cs_n), .dat_o(dat));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  function automatic logic [7:0] adr(input logic a, input logic rw);
    return {dsw_pkg::ADDR_UPPER, a, rw};
  endfunction : adr
  task automatic wr(input logic ok, input logic [7:0] ins, input int n);
    logic a;
    logic [7:0] q;
    host_u.start();
    host_u.xfer(adr(ok ~^ ad, 1'b0), q, a);
    chk({7'h0, a}, {7'h0, !ok}, "addr ack");
    host_u.xfer(ins, q, a);
    chk({7'h0, a}, {7'h0, !ok}, "instr ack");
    es = ok ? ins[5] : es;
    ew = (ok && ins[6]) ? 8'h80 : ew;
    repeat (n)
    begin
      q = 8'($urandom);
      ew = ok ? q : ew;
      host_u.xfer(q, q, a);
      chk({7'h0, a}, {7'h0, !ok}, "data ack");
    end
    chk(wiper, ew, "i2c wiper");
    chk({7'h0, shut}, {7'h0, es}, "shutdown");
    host_u.stop();
  endtask : wr
  task automatic rd();
    logic a;
    logic [7:0] q;
    host_u.start();
    host_u.xfer(adr(ad, 1'b1), q, a);
    chk({7'h0, a}, 8'h00, "read ack");
    host_u.xfer(8'hff, q, a);
    chk(q, ew, "read data");
    chk({7'h0, a}, 8'h01, "release");
    host_u.stop();
  endtask : rd
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      stop_test();
    end
  end
  initial
  begin
    logic [31:0] r;
    void'($urandom(37836));
    rst_n = 1'b0;
    sel = 1'b0;
    ad = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(wiper, 8'h80, "preset");
    foreach (nb[i])
    begin
      r = $urandom;
      host_u.spi(r, nb[i]);
      ew = r[7:0];
      chk(wiper, ew, "spi wiper");
      if (nb[i] == 16)
        chk(host_u.so[7:0], r[15:8], "chain");
    end
    sel = 1'b1;
    es = 1'b0;
    foreach (op[j])
    begin
      ad = j[0];
      repeat (4) @(negedge clk);
      wr(op[j][8], op[j][7:0] | (8'($urandom) & 8'h9f), nd[j]);
      rd();
    end
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk(wiper, 8'h80, "preset again");
    stop_test();
  end
endmodule : tb
`default_nettype wire
